/* File: luca_pkg.sv */
// Package of shared constants and types for the line unit control and alarm block.
package luca_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int NUM_CH = 3;

  // ---------------------------------------------------------------------------
  // Register byte offsets (APB, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;    // Per-channel selects and global pins.
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Alarm and mode status.
  localparam logic [7:0] OFS_VCOUNT = 8'h08;  // Violation counters.
  localparam logic [7:0] OFS_LOSS_IN = 8'h0C; // Loss-of-signal detector inputs per channel.

  // ---------------------------------------------------------------------------
  // Field positions in CTRL (per-channel fields: channel n at base + n)
  // ---------------------------------------------------------------------------
  localparam int CTRL_AONES_POS = 0;
  localparam int CTRL_LLB_POS = 4;
  localparam int CTRL_RLB_POS = 8;
  localparam int CTRL_THR_POS = 12;
  localparam int CTRL_E3_POS = 16;
  localparam int CTRL_MUTE_POS = 20;
  localparam int CTRL_HOST_POS = 21;
  localparam int CTRL_ICT_POS = 22;
  localparam logic [31:0] CTRL_RESET = 32'h0040_0000;  // Test pin high: normal.

  // Field positions in STATUS.
  localparam int STAT_DMO_POS = 0;
  localparam int STAT_LOS_POS = 4;
  localparam int STAT_LOL_POS = 8;
  localparam int STAT_MODE_POS = 12;  // Two bits per channel.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int DMO_PERIODS = 128;  // Nominal silent transmit clock periods.
  localparam int DMO_TOL = 32;       // Allowed spread on that count.
  localparam logic [7:0] DMO_LIMIT = 8'(DMO_PERIODS);
  // Lock window: compare counts over this many reference periods.
  localparam int LOCK_WINDOW = 1024;
  // 0.5 percent of the window, in periods.
  localparam int LOCK_TOL_PERMIL = 5;
  localparam logic [11:0] LOCK_TOL = 12'((LOCK_WINDOW * LOCK_TOL_PERMIL) / 1000);
  localparam logic [11:0] LOCK_WIN = 12'(LOCK_WINDOW);
  localparam logic [1:0] UNUSED_SLV = 2'h0;

  // Loopback modes.
  typedef enum logic [1:0] {
    LB_NONE,
    LB_ANALOG_LOCAL,
    LB_REMOTE,
    LB_DIGITAL_LOCAL
  } luca_loop_t;

  // Receive data mux sources.
  typedef enum logic [1:0] {
    RXS_LINE,
    RXS_TX_DATA,
    RXS_MUTED
  } luca_rxsrc_t;

endpackage : luca_pkg

/* File: luca_edge_sync.sv */
// Edge detector that turns a sampled clock-like input into one-cycle rise pulses.
`timescale 1ns/1ps
`default_nettype none
module luca_edge_sync (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Sampled level in.
  input wire logic level_in,
  // Registered rise pulse out.
  output logic rise_pulse
);

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  logic prev_q;  // Last sampled level.
  logic prev_d;
  logic rise_q;  // Registered pulse.
  logic rise_d;

  // Next values: a rise is a high level after a low one.
  always_comb begin
    prev_d = level_in;
    rise_d = level_in & ~prev_q;
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      rise_q <= rise_d;
    end
  end

  assign rise_pulse = rise_q;

endmodule : luca_edge_sync
`default_nettype wire

/* File: luca_top.sv */
// Control and alarm logic of a three-channel line interface unit, with APB access.
// Behaviour
// - Drive alarm after 128 silent transmit clocks
// - Drive alarm clears on next monitor pulse
// - All-ones select sends continuous bipolar ones
// - One mark per transmit clock period
// - Host mode ignores all-ones, loop, mute
// - Loss flag high while loss declared
// - Loss criteria differ for E3 versus DS3
// - Lock loss when clocks differ over 0.5%
// - Violation pulse per detected violation only
// - Test input low tristates all outputs
// - Threshold select: DS3/STS-1 only, static
// - Local high, remote low: analog local loop
// - Both high: digital local loop
// - Remote high, local low: remote loop
// - Mute enabled: rails low during loss
// - Mute disabled: rails pass during loss
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module luca_top
  import luca_pkg::*;
(
  // APB clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit side, per channel.
  input wire logic [NUM_CH-1:0] tx_clock,
  input wire logic [NUM_CH-1:0] tx_pos_data,
  input wire logic [NUM_CH-1:0] tx_neg_data,
  input wire logic [NUM_CH-1:0] monitor_tip_in,
  input wire logic [NUM_CH-1:0] monitor_ring_in,
  output logic [NUM_CH-1:0] tx_line_tip,
  output logic [NUM_CH-1:0] tx_line_ring,
  output logic [NUM_CH-1:0] tx_line_oe_n,
  // Receive side, per channel.
  input wire logic [NUM_CH-1:0] rx_recovered_clock,
  input wire logic [NUM_CH-1:0] reference_clock_in,
  input wire logic [NUM_CH-1:0] rx_line_pos,
  input wire logic [NUM_CH-1:0] rx_line_neg,
  input wire logic [NUM_CH-1:0] rx_violation_seen,
  output logic [NUM_CH-1:0] rx_positive_rail,
  output logic [NUM_CH-1:0] rx_negative_rail,
  // Alarm outputs, per channel.
  output logic [NUM_CH-1:0] drive_monitor_alarm,
  output logic [NUM_CH-1:0] rx_signal_loss_flag,
  output logic [NUM_CH-1:0] rx_lock_loss_flag,
  output logic [NUM_CH-1:0] code_violation_pulse,
  output logic [NUM_CH-1:0] rx_loopback_mode_lo,
  // Shared enable for all digital outputs (low while driving).
  output logic outputs_oe_n
);

  // ---------------------------------------------------------------------------
  // Decoding functions
  // ---------------------------------------------------------------------------
  // Loopback mode from the two selects; host mode forces none.
  function automatic luca_loop_t loop_decode(input logic llb, input logic rlb,
                                             input logic host);
    if (host) begin
      loop_decode = LB_NONE;
    end else begin
      case ({llb, rlb})
        2'b10: loop_decode = LB_ANALOG_LOCAL;
        2'b11: loop_decode = LB_DIGITAL_LOCAL;
        2'b01: loop_decode = LB_REMOTE;
        default: loop_decode = LB_NONE;
      endcase
    end
  endfunction : loop_decode

  // APB access phase for a given offset.
  function automatic logic hit(input logic [7:0] ofs);
    hit = psel & penable & (paddr == ofs);
  endfunction : hit

  // ---------------------------------------------------------------------------
  // APB register state
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_q;  // Control pins as written by software.
  logic [31:0] ctrl_d;
  logic [31:0] loss_in_q;  // Loss detector levels, E3 bank low, DS3 bank high.
  logic [31:0] loss_in_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic host_mode;  // Host mode pin, taken from control.
  logic mute_en;    // Shared mute enable.
  logic test_n;     // Shared in-circuit test, active low.
  logic [31:0] status_w;
  logic [31:0] vcount_w;

  assign host_mode = ctrl_q[CTRL_HOST_POS];
  assign mute_en = ctrl_q[CTRL_MUTE_POS] & ~host_mode;
  assign test_n = ctrl_q[CTRL_ICT_POS];

  // Bus next state: zero wait states, unmapped offsets answer with an error.
  always_comb begin
    ctrl_d = ctrl_q;
    loss_in_d = loss_in_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;  // Ready for the access phase that follows.
      pslverr_d = !(paddr == OFS_CTRL || paddr == OFS_STATUS ||
                    paddr == OFS_VCOUNT || paddr == OFS_LOSS_IN);
      case (paddr)
        OFS_CTRL: prdata_d = ctrl_q;
        OFS_STATUS: prdata_d = status_w;
        OFS_VCOUNT: prdata_d = vcount_w;
        OFS_LOSS_IN: prdata_d = loss_in_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (pwrite && hit(OFS_CTRL)) begin
      ctrl_d = pwdata;
    end
    if (pwrite && hit(OFS_LOSS_IN)) begin
      loss_in_d = pwdata;
    end
  end

  // Bus registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      loss_in_q <= 32'h0000_0000;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      loss_in_q <= loss_in_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // Per-channel logic
  // ---------------------------------------------------------------------------
  luca_loop_t [NUM_CH-1:0] loop_mode;
  logic [NUM_CH-1:0] dmo_q;
  logic [NUM_CH-1:0] los_q;
  logic [NUM_CH-1:0] lol_q;
  logic [NUM_CH-1:0] lcv_q;
  logic [NUM_CH-1:0] rpos_q;
  logic [NUM_CH-1:0] rneg_q;
  logic [NUM_CH-1:0] ttip_q;
  logic [NUM_CH-1:0] tring_q;
  logic [NUM_CH-1:0] lbm_q;
  logic [7:0] vcnt [NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic txr;  // One-cycle pulse per transmit clock rise.
      logic rcr;  // Recovered clock rise.
      logic rfr;  // Reference clock rise.
      logic [7:0] sil_q;  // Silent transmit periods.
      logic [7:0] sil_d;
      logic dmo_d;
      logic [11:0] ref_q;  // Reference periods in the window.
      logic [11:0] ref_d;
      logic [11:0] rec_q;  // Recovered periods in the window.
      logic [11:0] rec_d;
      logic lol_d;
      logic los_d;
      logic lcv_d;
      logic rpos_d;
      logic rneg_d;
      logic ttip_d;
      logic tring_d;
      logic mark_q;  // Alternating polarity of all-ones marks.
      logic mark_d;
      logic [7:0] vc_q;
      logic [7:0] vc_d;
      logic pulse_seen;
      luca_rxsrc_t src;

      luca_edge_sync u_tx (.pclk(pclk), .presetn(presetn), .level_in(tx_clock[ch]),
                           .rise_pulse(txr));
      luca_edge_sync u_rc (.pclk(pclk), .presetn(presetn),
                           .level_in(rx_recovered_clock[ch]), .rise_pulse(rcr));
      luca_edge_sync u_rf (.pclk(pclk), .presetn(presetn),
                           .level_in(reference_clock_in[ch]), .rise_pulse(rfr));

      assign loop_mode[ch] = loop_decode(ctrl_q[CTRL_LLB_POS + ch],
                                         ctrl_q[CTRL_RLB_POS + ch], host_mode);
      // Monitor taps idle high by pull-up, so low is a mark.
      assign pulse_seen = ~monitor_tip_in[ch] | ~monitor_ring_in[ch];

      // Channel next state.
      always_comb begin
        // Drive monitor: count silent transmit periods.
        sil_d = sil_q;
        dmo_d = dmo_q[ch];
        if (pulse_seen) begin
          sil_d = 8'h00;
          dmo_d = 1'b0;
        end else if (txr) begin
          if (sil_q >= DMO_LIMIT - 8'h01) begin
            dmo_d = 1'b1;
          end else begin
            sil_d = sil_q + 8'h01;
          end
        end
        // Lock: count recovered edges over a window of reference edges.
        ref_d = ref_q;
        rec_d = rcr ? rec_q + 12'h001 : rec_q;
        lol_d = lol_q[ch];
        if (rfr) begin
          if (ref_q == LOCK_WIN - 12'h001) begin
            lol_d = (rec_d > LOCK_WIN + LOCK_TOL) ||
                    (rec_d + LOCK_TOL < LOCK_WIN);
            ref_d = 12'h000;
            rec_d = 12'h000;
          end else begin
            ref_d = ref_q + 12'h001;
          end
        end
        // Loss: E3 bank or DS3 bank by E3 select; threshold select picks the bit within the DS3 bank.
        if (ctrl_q[CTRL_E3_POS + ch]) begin
          los_d = loss_in_q[ch];
        end else begin
          los_d = loss_in_q[16 + 2 * ch + {31'h0, ctrl_q[CTRL_THR_POS + ch]}];
        end
        // Violation pulse follows the detector, low otherwise.
        lcv_d = rx_violation_seen[ch];
        vc_d = (rx_violation_seen[ch] && vc_q != 8'hFF) ? vc_q + 8'h01 : vc_q;
        // Receive source.
        if (mute_en && los_q[ch]) begin
          src = RXS_MUTED;
        end else if (loop_mode[ch] == LB_ANALOG_LOCAL || loop_mode[ch] == LB_DIGITAL_LOCAL) begin
          src = RXS_TX_DATA;
        end else begin
          src = RXS_LINE;
        end
        case (src)
          RXS_TX_DATA: begin
            rpos_d = tx_pos_data[ch];
            rneg_d = tx_neg_data[ch];
          end
          RXS_MUTED: begin
            rpos_d = 1'b0;
            rneg_d = 1'b0;
          end
          default: begin
            rpos_d = rx_line_pos[ch];
            rneg_d = rx_line_neg[ch];
          end
        endcase
        // Transmit: all-ones alternates polarity.
        mark_d = mark_q;
        ttip_d = ttip_q[ch];
        tring_d = tring_q[ch];
        if (txr) begin
          if (ctrl_q[CTRL_AONES_POS + ch] && !host_mode) begin
            mark_d = ~mark_q;
            ttip_d = ~mark_q;
            tring_d = mark_q;
          end else if (loop_mode[ch] == LB_REMOTE) begin
            ttip_d = rx_line_pos[ch];
            tring_d = rx_line_neg[ch];
          end else begin
            ttip_d = tx_pos_data[ch];
            tring_d = tx_neg_data[ch];
          end
        end
      end

      // Channel registers only.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sil_q <= 8'h00;
          dmo_q[ch] <= 1'b0;
          ref_q <= 12'h000;
          rec_q <= 12'h000;
          lol_q[ch] <= 1'b0;
          los_q[ch] <= 1'b0;
          lcv_q[ch] <= 1'b0;
          rpos_q[ch] <= 1'b0;
          rneg_q[ch] <= 1'b0;
          ttip_q[ch] <= 1'b0;
          tring_q[ch] <= 1'b0;
          mark_q <= 1'b0;
          vc_q <= 8'h00;
          lbm_q[ch] <= 1'b0;
        end else begin
          sil_q <= sil_d;
          dmo_q[ch] <= dmo_d;
          ref_q <= ref_d;
          rec_q <= rec_d;
          lol_q[ch] <= lol_d;
          los_q[ch] <= los_d;
          lcv_q[ch] <= lcv_d;
          rpos_q[ch] <= rpos_d;
          rneg_q[ch] <= rneg_d;
          ttip_q[ch] <= ttip_d;
          tring_q[ch] <= tring_d;
          mark_q <= mark_d;
          vc_q <= vc_d;
          lbm_q[ch] <= (loop_mode[ch] != LB_NONE);
        end
      end

      assign vcnt[ch] = vc_q;
      assign status_w[STAT_MODE_POS + 2 * ch +: 2] = loop_mode[ch];
    end
  endgenerate

  // Status word and violation counters for software.
  assign status_w[STAT_DMO_POS +: 4] = {1'b0, dmo_q};
  assign status_w[STAT_LOS_POS +: 4] = {1'b0, los_q};
  assign status_w[STAT_LOL_POS +: 4] = {1'b0, lol_q};
  assign status_w[31:18] = {13'h0000, host_mode};
  assign vcount_w = {8'h00, vcnt[2], vcnt[1], vcnt[0]};

  // ---------------------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------------------
  // Registered so the pins change with the data flops.
  logic oe_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q <= 1'b0;
    end else begin
      oe_n_q <= ~test_n;
    end
  end

  assign outputs_oe_n = oe_n_q;
  assign tx_line_oe_n = {NUM_CH{oe_n_q}};
  assign tx_line_tip = ttip_q;
  assign tx_line_ring = tring_q;
  assign rx_positive_rail = rpos_q;
  assign rx_negative_rail = rneg_q;
  assign drive_monitor_alarm = dmo_q;
  assign rx_signal_loss_flag = los_q;
  assign rx_lock_loss_flag = lol_q;
  assign code_violation_pulse = lcv_q;
  assign rx_loopback_mode_lo = lbm_q;

endmodule : luca_top
`default_nettype wire

/* File: luca_properties.sv */
// Concurrent checks on the ports of the control and alarm block.
`timescale 1ns/1ps
`default_nettype none
module luca_properties
  import luca_pkg::*;
(
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel pins.
  input wire logic [NUM_CH-1:0] tx_clock,
  input wire logic [NUM_CH-1:0] monitor_tip_in,
  input wire logic [NUM_CH-1:0] monitor_ring_in,
  input wire logic [NUM_CH-1:0] tx_line_tip,
  input wire logic [NUM_CH-1:0] tx_line_ring,
  input wire logic [NUM_CH-1:0] rx_violation_seen,
  input wire logic [NUM_CH-1:0] rx_positive_rail,
  input wire logic [NUM_CH-1:0] rx_negative_rail,
  input wire logic [NUM_CH-1:0] drive_monitor_alarm,
  input wire logic [NUM_CH-1:0] rx_signal_loss_flag,
  input wire logic [NUM_CH-1:0] code_violation_pulse,
  input wire logic [NUM_CH-1:0] rx_loopback_mode_lo,
  input wire logic outputs_oe_n
);
  // ---------------------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;  // Control word as last written.
  logic tx_q, tx_d;  // Channel 0 transmit clock, delayed.
  logic [8:0] sil_q, sil_d;  // Channel 0 transmit periods without a mark.
  logic mark;  // A monitor tap of channel 0 sees a pulse.
  logic ones;  // Channel 0 should send all ones.

  // Next values; the silence count saturates.
  always_comb begin
    mark = !(monitor_tip_in[0] && monitor_ring_in[0]);
    ones = ctrl_q[0] && ctrl_q[CTRL_ICT_POS] && !ctrl_q[CTRL_HOST_POS];
    ones = ones && !ctrl_q[4] && !ctrl_q[8];
    ctrl_d = ctrl_q;
    if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
      ctrl_d = pwdata;
    end
    tx_d = tx_clock[0];
    sil_d = sil_q;
    if (mark) begin
      sil_d = 9'h000;
    end else if (tx_clock[0] && !tx_q && sil_q != 9'h1FF) begin
      sil_d = sil_q + 9'h001;
    end
  end

  // Registers of the shadow state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      tx_q <= 1'b0;
      sil_q <= 9'h000;
    end else begin
      ctrl_q <= ctrl_d;
      tx_q <= tx_d;
      sil_q <= sil_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("bad ready");
  bad_addr_a: assert property (psel && penable && pready && paddr > OFS_LOSS_IN |-> pslverr)
    else $error("no error");
  viol_follow_a: assert property (code_violation_pulse == $past(rx_violation_seen))
    else $error("bad pulse");
  dmo_silent_a: assert property ($rose(drive_monitor_alarm[0]) |-> sil_q inside {[9'h05E:9'h0A2]})
    else $error("early alarm");
  dmo_clear_a: assert property (drive_monitor_alarm[0] && mark |-> ##[1:4] !drive_monitor_alarm[0])
    else $error("alarm stuck");
  ones_alt_a: assert property (ones && ctrl_q == $past(ctrl_q, 12) |-> tx_line_tip[0] ^ tx_line_ring[0])
    else $error("no ones");
  mute_rails_a: assert property (ctrl_q[CTRL_MUTE_POS] && !ctrl_q[CTRL_HOST_POS] && $stable(ctrl_q)
    && rx_signal_loss_flag[0] && $past(rx_signal_loss_flag[0])
    |-> !rx_positive_rail[0] && !rx_negative_rail[0])
    else $error("not muted");
  test_float_a: assert property ($stable(ctrl_q[CTRL_ICT_POS]) |-> outputs_oe_n == !ctrl_q[CTRL_ICT_POS])
    else $error("bad enable");
  loop_flag_a: assert property ($stable(ctrl_q) && ctrl_q[CTRL_ICT_POS]
    |-> rx_loopback_mode_lo[0] == (!ctrl_q[CTRL_HOST_POS] && (ctrl_q[4] || ctrl_q[8])))
    else $error("bad loop flag");
endmodule : luca_properties

bind luca_top luca_properties luca_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .tx_clock(tx_clock), .monitor_tip_in(monitor_tip_in),
  .monitor_ring_in(monitor_ring_in), .tx_line_tip(tx_line_tip), .tx_line_ring(tx_line_ring),
  .rx_violation_seen(rx_violation_seen), .rx_positive_rail(rx_positive_rail),
  .rx_negative_rail(rx_negative_rail), .drive_monitor_alarm(drive_monitor_alarm),
  .rx_signal_loss_flag(rx_signal_loss_flag), .code_violation_pulse(code_violation_pulse),
  .rx_loopback_mode_lo(rx_loopback_mode_lo), .outputs_oe_n(outputs_oe_n));
`default_nettype wire

/* File: luca_far_model.sv */
// Behavioural model of the far-side clocks and the line monitor taps.
`timescale 1ns/1ps
`default_nettype none
module luca_far_model
  import luca_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Line outputs of the block and a detune control.
  input wire logic [NUM_CH-1:0] tx_line_tip,
  input wire logic [NUM_CH-1:0] tx_line_ring,
  input wire logic [NUM_CH-1:0] tx_line_oe_n,
  input wire logic [NUM_CH-1:0] slow_rx,
  // Clocks and taps towards the block.
  output logic [NUM_CH-1:0] tx_clock,
  output logic [NUM_CH-1:0] reference_clock_in,
  output logic [NUM_CH-1:0] rx_recovered_clock,
  output logic [NUM_CH-1:0] monitor_tip_in,
  output logic [NUM_CH-1:0] monitor_ring_in
);
  logic [2:0] ph_q, ph_d;  // Phase in a six-cycle period.
  logic [2:0] sp_q, sp_d;  // Phase in an eight-cycle period, far off lock.

  // Next phases of both dividers.
  always_comb begin
    ph_d = (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    sp_d = sp_q + 3'h1;
  end

  // Divider registers; all clocks change only just after a pclk edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 3'h0;
      sp_q <= 3'h0;
    end else begin
      ph_q <= ph_d;
      sp_q <= sp_d;
    end
  end

  // A detuned channel runs 25 percent slow.
  assign tx_clock = {NUM_CH{ph_q > 3'h2}};
  assign reference_clock_in = {NUM_CH{ph_q > 3'h2}};
  assign rx_recovered_clock = (slow_rx & {NUM_CH{sp_q[2]}}) | (~slow_rx & ~reference_clock_in);
  // Taps read low on a driven pulse and float to their pull-up otherwise.
  assign monitor_tip_in = ~(tx_line_tip & ~tx_line_oe_n);
  assign monitor_ring_in = ~(tx_line_ring & ~tx_line_oe_n);
endmodule : luca_far_model
`default_nettype wire

/* File: tb_luca_top.sv */
// Self-checking testbench of the control and alarm block.
`timescale 1ns/1ps
`default_nettype none
module tb_luca_top
  import luca_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oe_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_CH-1:0] txc, txp, txn, mtip, mring, tip, ring, toe, rclk, refc;
  logic [NUM_CH-1:0] rxp, rxn, viol, railp, railn, dma, los, lol, cvp, lbm, slow;
  int error_cnt, n_checks, cyc, n;

  luca_top luca_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock(txc), .tx_pos_data(txp), .tx_neg_data(txn),
    .monitor_tip_in(mtip), .monitor_ring_in(mring), .tx_line_tip(tip), .tx_line_ring(ring),
    .tx_line_oe_n(toe), .rx_recovered_clock(rclk), .reference_clock_in(refc),
    .rx_line_pos(rxp), .rx_line_neg(rxn), .rx_violation_seen(viol), .rx_positive_rail(railp),
    .rx_negative_rail(railn), .drive_monitor_alarm(dma), .rx_signal_loss_flag(los),
    .rx_lock_loss_flag(lol), .code_violation_pulse(cvp), .rx_loopback_mode_lo(lbm),
    .outputs_oe_n(oe_n));
  luca_far_model luca_far_model_inst (.pclk(pclk), .presetn(presetn), .tx_line_tip(tip),
    .tx_line_ring(ring), .tx_line_oe_n(toe), .slow_rx(slow), .tx_clock(txc),
    .reference_clock_in(refc), .rx_recovered_clock(rclk), .monitor_tip_in(mtip),
    .monitor_ring_in(mring));

  // Clock of 200 MHz.
  always #2.5 pclk = ~pclk;

  // Watchdog: the tests need about 15300 cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Compares with case equality.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; entered just after an edge, leaves one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // Register read.
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // Tip rises over twelve transmit periods.
  task automatic rises(input int ch, output int k);
    logic p;
    k = 0;
    p = tip[ch];
    repeat (72) begin
      @(posedge pclk);
      if (tip[ch] && !p) k++;
      p = tip[ch];
    end
  endtask : rises

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic e;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {txp, txn, rxp, rxn, viol, slow} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CTRL, r);
    check(r, CTRL_RESET);
    rd(OFS_VCOUNT, r);
    check(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check(32'(e), 32'h1);
    // Drive alarm waits its count, clears on a pulse.
    repeat (520) @(posedge pclk);
    check(32'(dma), 32'h0);
    repeat (480) @(posedge pclk);
    check(32'(dma), 32'h7);
    txp <= 3'b001;
    repeat (20) @(posedge pclk);
    check(32'(tip), 32'h1);
    check(32'(dma), 32'h6);
    txp <= 3'b000;
    // All ones on channel 0, then ignored in host mode.
    wr(OFS_CTRL, CTRL_RESET | 32'h1);
    repeat (20) @(posedge pclk);
    rises(0, n);
    check(32'(n), 32'h6);
    wr(OFS_CTRL, CTRL_RESET | 32'h0020_0001);
    repeat (20) @(posedge pclk);
    rises(0, n);
    check(32'(n), 32'h0);
    // Every loopback code on channel 2.
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, CTRL_RESET | (32'(i[0]) << 6) | (32'(i[1]) << 10));
      rd(OFS_STATUS, r);
      check(32'(r[17:16]), 32'(i));
      check(32'(lbm), 32'(i != 0) << 2);
    end
    wr(OFS_CTRL, CTRL_RESET | 32'h0020_0440);
    rd(OFS_STATUS, r);
    check(32'(r[18:16]), 32'h4);
    // Loss and mute; threshold of channel 1 fixed before use.
    rxp <= 3'b111;
    wr(OFS_CTRL, CTRL_RESET | 32'h0011_2000);
    wr(OFS_LOSS_IN, 32'h0001_0000);
    repeat (4) @(posedge pclk);
    check(32'(los), 32'h0);
    wr(OFS_LOSS_IN, 32'h0004_0001);
    repeat (4) @(posedge pclk);
    check(32'(los), 32'h1);
    check(32'(railp), 32'h6);
    wr(OFS_LOSS_IN, 32'h0008_0001);
    repeat (4) @(posedge pclk);
    check(32'(los), 32'h3);
    check(32'(railp), 32'h4);
    wr(OFS_CTRL, CTRL_RESET | 32'h0001_2000);
    repeat (4) @(posedge pclk);
    check(32'(railp), 32'h7);
    wr(OFS_LOSS_IN, 32'h0);
    // One violation on channel 1.
    viol <= 3'b010;
    @(posedge pclk);
    viol <= 3'b000;
    repeat (3) @(posedge pclk);
    rd(OFS_VCOUNT, r);
    check(r, 32'h0000_0100);
    // Test input low floats outputs.
    wr(OFS_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    check(32'(oe_n), 32'h1);
    wr(OFS_CTRL, CTRL_RESET);
    // Detuned recovered clock on channel 2 only.
    slow <= 3'b100;
    repeat (14000) @(posedge pclk);
    check(32'(lol), 32'h4);
    report_and_stop();
  end
endmodule : tb_luca_top
`default_nettype wire
